// ===== inc/odj_pkg.sv
// Purpose: shared constants and types for the opcode decoder slice
// Assumes: 16-bit instruction words, 32-bit AHB-Lite register bus
// Notes: cycle figures are held in quarter-cycle units
package odj_pkg;

  // register byte offsets
  localparam logic [7:0] ODJ_OFS_INSTR = 8'h00;
  localparam logic [7:0] ODJ_OFS_OPER = 8'h04;
  localparam logic [7:0] ODJ_OFS_CTRL = 8'h08;
  localparam logic [7:0] ODJ_OFS_RESULT = 8'h0c;
  localparam logic [7:0] ODJ_OFS_CYCLES = 8'h10;
  localparam logic [7:0] ODJ_OFS_STATE = 8'h14;
  localparam logic [7:0] ODJ_OFS_BUS = 8'h18;

  // control register field positions
  localparam int ODJ_CTL_SENSE = 0;
  localparam int ODJ_CTL_WRAP = 1;
  localparam int ODJ_CTL_BYTE = 2;
  localparam int ODJ_CTL_RESP = 3;
  localparam int ODJ_CTL_LVL_LO = 8;
  localparam int ODJ_CTL_WORDS_LO = 16;

  // reset values
  localparam logic [31:0] ODJ_RST_WORD = 32'h0000_0000;
  localparam logic ODJ_RST_PWR_IRQ = 1'b0;
  localparam logic ODJ_RST_WRITABLE = 1'b1;

  // exact opcodes
  localparam logic [15:0] ODJ_OP_PWR_ON = 16'h4002;
  localparam logic [15:0] ODJ_OP_PWR_OFF = 16'h4003;
  localparam logic [15:0] ODJ_OP_RAM = 16'h4045;
  localparam logic [15:0] ODJ_OP_ROM = 16'h4046;
  localparam logic [15:0] ODJ_OP_SW_ACC = 16'h5801;
  localparam logic [15:0] ODJ_OP_SW_IDX = 16'h5b01;
  localparam logic [15:0] ODJ_OP_ST_ACC = 16'h6c00;
  localparam logic [15:0] ODJ_OP_ST_IDX = 16'h6e00;
  localparam logic [15:0] ODJ_OP_ST_INH = 16'h6800;

  // jump bases, low six bits are displacement
  localparam logic [15:0] ODJ_JMP_GE = 16'h3e80;
  localparam logic [15:0] ODJ_JMP_NE = 16'h3f00;
  localparam logic [15:0] ODJ_JMP_GT = 16'h3f80;
  localparam logic [15:0] ODJ_JMP_MASK = 16'hff80;
  localparam int ODJ_JMP_BACK_BIT = 6;

  // high-byte bases of the I/O group
  localparam logic [7:0] ODJ_HB_SEL_ACC = 8'h44;
  localparam logic [7:0] ODJ_HB_SEL_IDX = 8'h46;
  localparam logic [7:0] ODJ_HB_PROBE_SILENT = 8'h48;
  localparam logic [7:0] ODJ_HB_PROBE_ANSWER = 8'h49;
  localparam logic [7:0] ODJ_HB_WORD_IN = 8'h58; // 58..5f
  localparam logic [7:0] ODJ_HB_OUT_ZERO = 8'h68; // 68/69
  localparam logic [7:0] ODJ_HB_OUT_ACC = 8'h6c; // 6c/6d
  localparam logic [7:0] ODJ_HB_OUT_IDX = 8'h6e; // 6e/6f
  localparam logic [7:0] ODJ_HB_BLK_IN = 8'h71;
  localparam logic [7:0] ODJ_HB_BLK_OUT = 8'h75;
  localparam logic [7:0] ODJ_HB_BYTE_IN = 8'h78; // 78..7f

  // memory-reference groups on opcode bits 15:11
  localparam logic [4:0] ODJ_MR_AND = 5'h10;
  localparam logic [4:0] ODJ_MR_ADD = 5'h11;
  localparam logic [4:0] ODJ_MR_SUB = 5'h12;
  localparam logic [4:0] ODJ_MR_STORE = 5'h13;
  localparam logic [2:0] ODJ_STORE_MODES = 3'h4; // 9800..9b00 only
  localparam logic [2:0] ODJ_MODE_FWD_DIR = 3'h2;
  localparam logic [2:0] ODJ_MODE_BWD_DIR = 3'h6;

  // timing in quarter cycles
  localparam logic [19:0] ODJ_Q_JUMP = 20'h00004; // 1
  localparam logic [19:0] ODJ_Q_IO = 20'h00005; // 1-1/4
  localparam logic [19:0] ODJ_Q_MEM = 20'h00008; // 2
  localparam logic [19:0] ODJ_Q_BYTE_IND = 20'h0000c; // 3
  localparam logic [19:0] ODJ_Q_PER_LEVEL = 20'h00004; // 1 per level
  localparam logic [19:0] ODJ_Q_PER_WORD = 20'h00006; // 1-1/2 per word

  typedef enum logic [4:0] {
    OC_NONE, OC_JUMP, OC_PWR_ON, OC_PWR_OFF, OC_MEM_RAM, OC_MEM_ROM,
    OC_SEL_ACC, OC_SEL_IDX, OC_PROBE, OC_WORD_IN, OC_SWITCH_IN, OC_OUT,
    OC_STATUS_OUT, OC_STATUS_INH, OC_BLOCK_IN, OC_BLOCK_OUT, OC_BYTE_IN,
    OC_AND, OC_ADD, OC_SUB, OC_STORE
  } odj_class_t;

  typedef enum logic [1:0] {
    BS_NONE, BS_ACC, BS_IDX, BS_ZERO
  } odj_src_t;

  // decoded instruction, 20 bits
  typedef struct packed {
    odj_class_t cls;
    odj_src_t bus_src;
    logic taken;
    logic backward;
    logic skip;
    logic to_index;
    logic masked;
    logic cond;
    logic done;
    logic byte_op;
    logic byte_sel;
    logic indirect;
    logic [2:0] mode;
  } odj_dec_t;

  // operand and flag context of a decode
  typedef struct packed {
    logic [15:0] words;
    logic [3:0] levels;
    logic resp;
    logic byte_mode;
    logic wrap;
    logic sense;
    logic [15:0] index;
    logic [15:0] accum;
  } odj_ctx_t;

endpackage

// ===== rtl/odj_decoder.sv
// Purpose: decode of jump, I/O and memory-reference opcodes 3e80..9bff
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: writing the instruction register starts one decode
//
// Functional notes
// RQ1: jump 3e80/3ec0 when X nonzero, A>=0, toggle on, wrap clear; one cycle.
// RQ2: jump 3f00/3f40 when X nonzero, A nonzero, toggle on, wrap clear.
// RQ3: jump 3f80/3fc0 when X nonzero, A>0, toggle on, wrap clear.
// RQ4: 4002 enables, 4003 disables power-loss interrupt; one and a quarter cycles.
// RQ5: 4045 makes memory writable, 4046 makes it read-only.
// RQ6: 4400 base selects a peripheral while presenting A on the bus.
// RQ7: 4600 base selects a peripheral while presenting X on the bus.
// RQ8: 4800 skips on no response, 4900 skips on a response.
// RQ9: 5800 inputs word to A unconditionally, 5900 only on response.
// RQ10: 5a00 inputs word to X unconditionally, 5b00 only on response.
// RQ11: masked word input at 5c00, 5d00, 5e00, 5f00.
// RQ12: 5801 loads switches into A, 5b01 into X.
// RQ13: output zeros 6800/6900, A 6c00/6d00, X 6e00/6f00; odd waits response.
// RQ14: 6c00 writes status from A, 6e00 from X, 6800 inhibits status.
// RQ15: block input 7100, output 7500; two cycles plus 1-1/2 per word.
// RQ16: byte input A 7800/7900, X 7a00/7b00; masked forms 7c00..7f00.
// RQ17: bits 10:8 of memory-reference opcodes select one of eight modes.
// RQ18: word AND 8000..8700; direct two cycles, indirect adds indirection cost.
// RQ19: add 8800..8f00 and subtract 9000..9700 share the mode decode.
// RQ20: byte mode: forward direct slot is byte 0, backward slot byte 1.
// RQ21: byte forms take three cycles indirect, two cycles direct.
// RQ22: store A uses 9800..9b00 with the same mode decode.
// RQ23: each indirection level adds one cycle to word forms.
// RQ24: a byte-mode qualifier held before the instruction selects byte forms.
`timescale 1ns/1ps

module odj_decoder
  import odj_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic dec_done,
  output logic power_loss_irq_en,
  output logic mem_writable
);

  // refuse address widths that the register decode cannot serve
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("odj_decoder: ADDR_W must lie in 8..32");
  end

  // bus phase capture
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  // software-visible storage
  logic [15:0] instr_ff;
  logic [31:0] oper_ff;
  logic [31:0] ctrl_ff;
  odj_dec_t result_ff;
  logic [19:0] cycles_ff;
  logic [15:0] bus_ff;
  logic pwr_irq_ff;
  logic writable_ff;
  logic status_inh_ff;
  logic go_ff;
  logic done_ff;
  // combinational
  logic addr_ok;
  logic req_wr;
  logic req_rd;
  logic [31:0] rd_mux;
  odj_ctx_t ctx;
  odj_dec_t nxt_dec;
  logic [19:0] nxt_cycles;
  logic [15:0] nxt_bus;

  // an address phase asks for a transfer when selected and htrans is NONSEQ or SEQ
  function automatic logic xfer_req(input logic sel, input logic [1:0] trans);
    return sel && trans[1];
  endfunction

  // compare the high byte of an opcode against a base
  function automatic logic hb_is(input logic [15:0] op, input logic [7:0] base);
    return op[15:8] == base;
  endfunction

  // compare a jump opcode, ignoring direction and displacement
  function automatic logic jmp_is(input logic [15:0] op, input logic [15:0] base);
    return (op & ODJ_JMP_MASK) == base;
  endfunction

  // compare the top seven bits, an even and odd base pair
  function automatic logic pair_is(input logic [15:0] op, input logic [7:0] base);
    return op[15:9] == base[7:1];
  endfunction

  // compare the top five bits, a group of eight bases
  function automatic logic oct_is(input logic [15:0] op, input logic [7:0] base);
    return op[15:11] == base[7:3];
  endfunction

  // a conditional transfer completes only when the peripheral answers
  function automatic logic io_done(input logic cond_bit, input logic resp);
    return !cond_bit || resp;
  endfunction

  // full decode of one opcode in its operand and flag context
  function automatic odj_dec_t decode(input logic [15:0] op, input odj_ctx_t c);
    odj_dec_t d;
    logic xnz;
    logic anz;
    logic ageq;
    logic gate;
    d = '0;
    d.cls = OC_NONE;
    d.bus_src = BS_NONE;
    xnz = c.index != 16'h0000;
    anz = c.accum != 16'h0000;
    ageq = ~c.accum[15];
    // every jump test needs X nonzero, toggle on and wrap clear
    gate = xnz && c.sense && !c.wrap;
    d.done = 1'b1;
    if (jmp_is(op, ODJ_JMP_GE)) begin
      d.cls = OC_JUMP;
      d.backward = op[ODJ_JMP_BACK_BIT];
      d.taken = gate && ageq; // RQ1
    end else if (jmp_is(op, ODJ_JMP_NE)) begin
      d.cls = OC_JUMP;
      d.backward = op[ODJ_JMP_BACK_BIT];
      d.taken = gate && anz; // RQ2
    end else if (jmp_is(op, ODJ_JMP_GT)) begin
      d.cls = OC_JUMP;
      d.backward = op[ODJ_JMP_BACK_BIT];
      d.taken = gate && ageq && anz; // RQ3
    end else if (op == ODJ_OP_PWR_ON) begin
      d.cls = OC_PWR_ON; // RQ4
    end else if (op == ODJ_OP_PWR_OFF) begin
      d.cls = OC_PWR_OFF; // RQ4
    end else if (op == ODJ_OP_RAM) begin
      d.cls = OC_MEM_RAM; // RQ5
    end else if (op == ODJ_OP_ROM) begin
      d.cls = OC_MEM_ROM; // RQ5
    end else if (hb_is(op, ODJ_HB_SEL_ACC)) begin
      d.cls = OC_SEL_ACC;
      d.bus_src = BS_ACC; // RQ6
    end else if (hb_is(op, ODJ_HB_SEL_IDX)) begin
      d.cls = OC_SEL_IDX;
      d.bus_src = BS_IDX; // RQ7
    end else if (hb_is(op, ODJ_HB_PROBE_SILENT)) begin
      d.cls = OC_PROBE;
      d.skip = !c.resp; // RQ8
    end else if (hb_is(op, ODJ_HB_PROBE_ANSWER)) begin
      d.cls = OC_PROBE;
      d.skip = c.resp; // RQ8
    end else if (op == ODJ_OP_SW_ACC || op == ODJ_OP_SW_IDX) begin
      // exact switch opcodes win over the word input bases
      d.cls = OC_SWITCH_IN;
      d.to_index = op == ODJ_OP_SW_IDX; // RQ12
    end else if (oct_is(op, ODJ_HB_WORD_IN)) begin
      d.cls = OC_WORD_IN; // RQ9 RQ10 RQ11
      d.cond = op[8];
      d.to_index = op[9];
      d.masked = op[10];
      d.done = io_done(op[8], c.resp);
    end else if (op == ODJ_OP_ST_ACC || op == ODJ_OP_ST_IDX) begin
      // exact status opcodes win over the output bases
      d.cls = OC_STATUS_OUT; // RQ14
      d.bus_src = (op == ODJ_OP_ST_IDX) ? BS_IDX : BS_ACC;
    end else if (op == ODJ_OP_ST_INH) begin
      d.cls = OC_STATUS_INH; // RQ14
    end else if (pair_is(op, ODJ_HB_OUT_ZERO) || pair_is(op, ODJ_HB_OUT_ACC) ||
                 pair_is(op, ODJ_HB_OUT_IDX)) begin
      d.cls = OC_OUT; // RQ13
      d.cond = op[8];
      d.done = io_done(op[8], c.resp);
      if (pair_is(op, ODJ_HB_OUT_ZERO)) begin
        d.bus_src = BS_ZERO;
      end else if (pair_is(op, ODJ_HB_OUT_ACC)) begin
        d.bus_src = BS_ACC;
      end else begin
        d.bus_src = BS_IDX;
      end
    end else if (hb_is(op, ODJ_HB_BLK_IN)) begin
      d.cls = OC_BLOCK_IN; // RQ15
    end else if (hb_is(op, ODJ_HB_BLK_OUT)) begin
      d.cls = OC_BLOCK_OUT; // RQ15
    end else if (oct_is(op, ODJ_HB_BYTE_IN)) begin
      d.cls = OC_BYTE_IN; // RQ16
      d.cond = op[8];
      d.to_index = op[9];
      d.masked = op[10];
      d.done = io_done(op[8], c.resp);
    end else if (op[15:11] == ODJ_MR_AND || op[15:11] == ODJ_MR_ADD || op[15:11] == ODJ_MR_SUB ||
                 (op[15:11] == ODJ_MR_STORE && op[10:8] < ODJ_STORE_MODES)) begin
      // byte forms share the word opcodes, told apart by the held qualifier
      unique case (op[15:11])
        ODJ_MR_AND: d.cls = OC_AND; // RQ18
        ODJ_MR_ADD: d.cls = OC_ADD; // RQ19
        ODJ_MR_SUB: d.cls = OC_SUB; // RQ19
        default: d.cls = OC_STORE; // RQ22
      endcase
      d.mode = op[10:8]; // RQ17
      d.indirect = op[8];
      d.byte_op = c.byte_mode; // RQ24
      d.byte_sel = c.byte_mode && (op[10:8] == ODJ_MODE_BWD_DIR); // RQ20
    end
    return d;
  endfunction

  // execution time of a decoded instruction in quarter cycles
  function automatic logic [19:0] cost(input odj_dec_t d, input odj_ctx_t c);
    logic [19:0] q;
    q = '0;
    unique case (d.cls)
      OC_NONE: q = '0;
      OC_JUMP: q = ODJ_Q_JUMP; // RQ1
      OC_BLOCK_IN, OC_BLOCK_OUT: q = ODJ_Q_MEM + 20'(ODJ_Q_PER_WORD * 20'(c.words)); // RQ15
      OC_AND, OC_ADD, OC_SUB, OC_STORE: begin
        if (!d.indirect) begin
          q = ODJ_Q_MEM; // RQ18 RQ21
        end else if (d.byte_op) begin
          q = ODJ_Q_BYTE_IND; // RQ21
        end else begin
          q = ODJ_Q_MEM + 20'(ODJ_Q_PER_LEVEL * 20'(c.levels)); // RQ23
        end
      end
      default: q = ODJ_Q_IO; // RQ4
    endcase
    return q;
  endfunction

  // operand context drawn from the registers
  always_comb begin
    ctx = '0;
    ctx.accum = oper_ff[15:0];
    ctx.index = oper_ff[31:16];
    ctx.sense = ctrl_ff[ODJ_CTL_SENSE];
    ctx.wrap = ctrl_ff[ODJ_CTL_WRAP];
    ctx.byte_mode = ctrl_ff[ODJ_CTL_BYTE];
    ctx.resp = ctrl_ff[ODJ_CTL_RESP];
    ctx.levels = ctrl_ff[ODJ_CTL_LVL_LO +: 4];
    ctx.words = ctrl_ff[ODJ_CTL_WORDS_LO +: 16];
  end

  // decode and bus value for the held instruction
  always_comb begin
    nxt_dec = decode(instr_ff, ctx);
    nxt_cycles = cost(nxt_dec, ctx);
    unique case (nxt_dec.bus_src)
      BS_ACC: nxt_bus = ctx.accum;
      BS_IDX: nxt_bus = ctx.index;
      BS_ZERO: nxt_bus = 16'h0000;
      BS_NONE: nxt_bus = 16'h0000;
    endcase
  end

  // address decode, every mapped word is a whole aligned register
  assign addr_ok = (haddr[1:0] == 2'b00) && (haddr[ADDR_W-1:2] <= (ADDR_W-2)'(ODJ_OFS_BUS[7:2]));
  // write and read requests of the address phase
  assign req_wr = xfer_req(hsel, htrans) && hwrite && addr_ok;
  assign req_rd = xfer_req(hsel, htrans) && !hwrite;

  // read mux, unmapped words read zero
  always_comb begin
    unique case (haddr[7:0])
      ODJ_OFS_INSTR: rd_mux = {16'h0000, instr_ff};
      ODJ_OFS_OPER: rd_mux = oper_ff;
      ODJ_OFS_CTRL: rd_mux = ctrl_ff;
      ODJ_OFS_RESULT: rd_mux = {12'h000, result_ff};
      ODJ_OFS_CYCLES: rd_mux = {12'h000, cycles_ff};
      ODJ_OFS_STATE: rd_mux = {29'h0000_0000, status_inh_ff, writable_ff, pwr_irq_ff};
      ODJ_OFS_BUS: rd_mux = {16'h0000, bus_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // address phase capture for writes and read data
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= ODJ_RST_WORD;
    end else if (hready) begin
      wr_pend_ff <= req_wr;
      wr_addr_ff <= haddr[7:0];
      // read data is taken here so that it stands through the data phase
      if (req_rd && addr_ok) begin
        hrdata_ff <= rd_mux;
      end else if (req_rd) begin
        hrdata_ff <= ODJ_RST_WORD;
      end
    end
  end

  // data phase writes of software registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      instr_ff <= 16'h0000;
      oper_ff <= ODJ_RST_WORD;
      ctrl_ff <= ODJ_RST_WORD;
    end else if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        ODJ_OFS_INSTR: instr_ff <= hwdata[15:0];
        ODJ_OFS_OPER: oper_ff <= hwdata;
        ODJ_OFS_CTRL: ctrl_ff <= hwdata;
        default: instr_ff <= instr_ff;
      endcase
    end
  end

  // decode start pulse raised on the same edge the instruction lands
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      go_ff <= 1'b0;
    end else begin
      go_ff <= wr_pend_ff && (wr_addr_ff == ODJ_OFS_INSTR);
    end
  end

  // latch decode results
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result_ff <= '0;
      cycles_ff <= 20'h00000;
      bus_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= go_ff;
      if (go_ff) begin
        result_ff <= nxt_dec;
        cycles_ff <= nxt_cycles;
        bus_ff <= nxt_bus; // RQ6 RQ7 RQ13
      end
    end
  end

  // processor control state changed by decoded opcodes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwr_irq_ff <= ODJ_RST_PWR_IRQ;
      writable_ff <= ODJ_RST_WRITABLE;
      status_inh_ff <= 1'b0;
    end else if (go_ff) begin
      unique case (nxt_dec.cls)
        OC_PWR_ON: pwr_irq_ff <= 1'b1; // RQ4
        OC_PWR_OFF: pwr_irq_ff <= 1'b0; // RQ4
        OC_MEM_RAM: writable_ff <= 1'b1; // RQ5
        OC_MEM_ROM: writable_ff <= 1'b0; // RQ5
        OC_STATUS_INH: status_inh_ff <= 1'b1; // RQ14
        OC_STATUS_OUT: status_inh_ff <= 1'b0; // RQ14
        default: status_inh_ff <= status_inh_ff;
      endcase
    end
  end

  // bus answers and status outputs
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign dec_done = done_ff;
  assign power_loss_irq_en = pwr_irq_ff;
  assign mem_writable = writable_ff;

endmodule // odj_decoder

// ===== dv/odj_asserts.sv
// Purpose: port assertions for the opcode decoder
// Assumes: single clock, synchronous active-high reset
// Notes: bound from the testbench top
`timescale 1ns/1ps
module odj_asserts
  import odj_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic dec_done,
  input wire logic power_loss_irq_en,
  input wire logic mem_writable
);
  logic go_wr;
  logic dp_ff;
  logic [15:0] op_ff;
  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);
  // instruction write taken in its address phase
  assign go_wr = hsel && hready && htrans[1] && hwrite && haddr == ADDR_W'(ODJ_OFS_INSTR);
  // keep the last opcode written, for the mode checks
  always_ff @(posedge clock) begin
    dp_ff <= go_wr && !sys_rst;
    if (dp_ff) begin
      op_ff <= hwdata[15:0];
    end
  end
  AST_READY: assert property (hreadyout) else $error("wait state seen");
  AST_OKAY: assert property (!hresp) else $error("error response seen");
  AST_RST: assert property ($past(sys_rst) |-> !dec_done && !power_loss_irq_en && mem_writable && hrdata == 32'h0)
    else $error("bad output after reset");
  AST_PULSE: assert property (dec_done |=> !dec_done) else $error("done held too long");
  AST_LAT: assert property (go_wr |-> ##[2:8] dec_done) else $error("decode never finished");
  AST_IRQ_CHG: assert property ($changed(power_loss_irq_en) |-> dec_done) else $error("irq enable moved alone");
  AST_MEM_CHG: assert property ($changed(mem_writable) |-> dec_done) else $error("memory mode moved alone");
  AST_PWR_ON: assert property (dec_done && op_ff == ODJ_OP_PWR_ON |-> power_loss_irq_en)
    else $error("irq enable not set");
  AST_PWR_OFF: assert property (dec_done && op_ff == ODJ_OP_PWR_OFF |-> !power_loss_irq_en)
    else $error("irq enable not cleared");
  AST_RAM: assert property (dec_done && op_ff == ODJ_OP_RAM |-> mem_writable)
    else $error("memory not writable");
  AST_ROM: assert property (dec_done && op_ff == ODJ_OP_ROM |-> !mem_writable)
    else $error("memory not read-only");
endmodule // odj_asserts

// ===== dv/odj_ahb_master.sv
// Purpose: register bus master standing in for the processor side
// Assumes: single word transfers, slave may insert waits
// Notes: raises hang when a wait runs past its bound
`timescale 1ns/1ps
module odj_ahb_master (
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hang
);
  // bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hang = 1'b0;
  end
  // hold the current phase until hready is sampled high
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      hang <= 1'b1;
    end
  endtask
  // one transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
endmodule // odj_ahb_master

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: decode ends with a done pulse, results then readable
// Notes: expected fields follow the result register layout
`timescale 1ns/1ps
module tb_top
  import odj_pkg::*;
;
  logic clock;
  logic sys_rst;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic dec_done;
  logic power_loss_irq_en;
  logic mem_writable;
  logic hang;
  logic [31:0] q;
  logic [31:0] v;
  logic [31:0] c;
  int err_total;
  int n_checks;
  odj_class_t grp [4] = '{OC_AND, OC_ADD, OC_SUB, OC_STORE};
  odj_decoder dut_u (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dec_done(dec_done), .power_loss_irq_en(power_loss_irq_en), .mem_writable(mem_writable)
  );
  odj_ahb_master mst_u (
    .clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang)
  );
  // clock source
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // counts and verdict
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    mst_u.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // load operands and flags, start a decode, check class, fields and time
  task automatic run(input logic [15:0] op, input logic [31:0] oper, ctl, input odj_class_t cls,
      input logic [31:0] msk, val, cyc);
    int k;
    mst_u.xfer(1'b1, ODJ_OFS_OPER, oper, q);
    mst_u.xfer(1'b1, ODJ_OFS_CTRL, ctl, q);
    mst_u.xfer(1'b1, ODJ_OFS_INSTR, {16'h0, op}, q);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (dec_done !== 1'b1 && k < 16);
    if (dec_done !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    mst_u.xfer(1'b0, ODJ_OFS_RESULT, 32'h0, q);
    chk({27'h0, q[19:15]}, {27'h0, cls});
    chk(q & msk, val);
    rd(ODJ_OFS_CYCLES, cyc);
  endtask
  task automatic jp(input logic [15:0] op, input logic [31:0] xa, ctl, val);
    run(op, xa, ctl, OC_JUMP, 32'h1800, val, 32'h4);
  endtask
  task automatic io(input logic [15:0] op, input logic [31:0] ctl, input odj_class_t cls, input logic [31:0] m, e);
    run(op, 32'habcd_1234, ctl, cls, m, e, 32'h5);
  endtask
  // a stuck bus ends the run
  always @(posedge hang) begin
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk({30'h0, power_loss_irq_en, mem_writable}, 32'h1);
    rd(ODJ_OFS_STATE, 32'h2);
    rd(8'h1c, 32'h0);
    io(16'h4002, 32'h0, OC_PWR_ON, 32'h0, 32'h0);
    rd(ODJ_OFS_STATE, 32'h3);
    io(16'h4003, 32'h0, OC_PWR_OFF, 32'h0, 32'h0);
    chk({31'h0, power_loss_irq_en}, 32'h0);
    io(16'h4046, 32'h0, OC_MEM_ROM, 32'h0, 32'h0);
    chk({31'h0, mem_writable}, 32'h0);
    io(16'h4045, 32'h0, OC_MEM_RAM, 32'h0, 32'h0);
    chk({31'h0, mem_writable}, 32'h1);
    io(16'h4002, 32'h0, OC_PWR_ON, 32'h0, 32'h0);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk({30'h0, power_loss_irq_en, mem_writable}, 32'h1);
    jp(16'h3e80, 32'h0001_0000, 32'h1, 32'h1000);
    jp(16'h3ec0, 32'h0001_8000, 32'h1, 32'h0800);
    jp(16'h3e80, 32'h0001_0000, 32'h3, 32'h0);
    jp(16'h3f00, 32'h0001_0000, 32'h1, 32'h0);
    jp(16'h3f40, 32'h0001_fffb, 32'h1, 32'h1800);
    jp(16'h3f80, 32'h0000_0001, 32'h1, 32'h0);
    jp(16'h3f80, 32'h0002_0000, 32'h1, 32'h0);
    jp(16'h3f80, 32'h0001_8000, 32'h1, 32'h0);
    jp(16'h3fc0, 32'h0002_0001, 32'h0, 32'h0800);
    jp(16'h3fc0, 32'h0002_0001, 32'h1, 32'h1800);
    io(16'h4400, 32'h0, OC_SEL_ACC, 32'h6000, 32'h2000);
    rd(ODJ_OFS_BUS, 32'h1234);
    io(16'h4600, 32'h0, OC_SEL_IDX, 32'h6000, 32'h4000);
    rd(ODJ_OFS_BUS, 32'habcd);
    io(16'h4800, 32'h0, OC_PROBE, 32'h400, 32'h400);
    io(16'h4800, 32'h8, OC_PROBE, 32'h400, 32'h0);
    io(16'h4900, 32'h8, OC_PROBE, 32'h400, 32'h400);
    io(16'h4900, 32'h0, OC_PROBE, 32'h400, 32'h0);
    io(16'h5800, 32'h0, OC_WORD_IN, 32'h380, 32'h0);
    io(16'h5900, 32'h0, OC_WORD_IN, 32'h3c0, 32'h080);
    io(16'h5900, 32'h8, OC_WORD_IN, 32'h3c0, 32'h0c0);
    io(16'h5a00, 32'h0, OC_WORD_IN, 32'h380, 32'h200);
    io(16'h5b00, 32'h8, OC_WORD_IN, 32'h3c0, 32'h2c0);
    io(16'h5c00, 32'h0, OC_WORD_IN, 32'h380, 32'h100);
    io(16'h5d00, 32'h8, OC_WORD_IN, 32'h3c0, 32'h1c0);
    io(16'h5e00, 32'h0, OC_WORD_IN, 32'h380, 32'h300);
    io(16'h5f00, 32'h0, OC_WORD_IN, 32'h3c0, 32'h380);
    io(16'h5801, 32'h0, OC_SWITCH_IN, 32'h200, 32'h0);
    io(16'h5b01, 32'h0, OC_SWITCH_IN, 32'h200, 32'h200);
    io(16'h6900, 32'h8, OC_OUT, 32'h6080, 32'h6080);
    rd(ODJ_OFS_BUS, 32'h0);
    io(16'h6d00, 32'h8, OC_OUT, 32'h6080, 32'h2080);
    rd(ODJ_OFS_BUS, 32'h1234);
    io(16'h6f00, 32'h8, OC_OUT, 32'h6080, 32'h4080);
    io(16'h6800, 32'h0, OC_STATUS_INH, 32'h0, 32'h0);
    rd(ODJ_OFS_STATE, 32'h6);
    io(16'h6e00, 32'h0, OC_STATUS_OUT, 32'h0, 32'h0);
    rd(ODJ_OFS_STATE, 32'h2);
    io(16'h6c00, 32'h0, OC_STATUS_OUT, 32'h0, 32'h0);
    run(16'h7100, 32'h0, 32'h0003_0000, OC_BLOCK_IN, 32'h0, 32'h0, 32'h1a);
    run(16'h7500, 32'h0, 32'h0, OC_BLOCK_OUT, 32'h0, 32'h0, 32'h8);
    run(16'h7500, 32'h0, 32'hffff_0000, OC_BLOCK_OUT, 32'h0, 32'h0, 32'h6_0002);
    io(16'h7800, 32'h0, OC_BYTE_IN, 32'h380, 32'h0);
    io(16'h7b00, 32'h8, OC_BYTE_IN, 32'h3c0, 32'h2c0);
    io(16'h7c00, 32'h0, OC_BYTE_IN, 32'h380, 32'h100);
    io(16'h7f00, 32'h0, OC_BYTE_IN, 32'h3c0, 32'h380);
    // every mode of each memory group (store modes 0..3 only), word then byte, indirection depth = mode
    for (int b = 0; b < 2; b++) begin
      for (int g = 0; g < 4; g++) begin
        for (int m = 0; m < 8; m++) begin
          if (g < 3 || m < 4) begin
            v = {26'h0, b[0], b == 1 && m == 6, m[0], m[2:0]};
            c = !m[0] ? 32'h8 : (b == 1 ? 32'hc : 32'h8 + 32'(4 * m));
            run({5'h10 + 5'(g), 3'(m), 8'h0}, 32'h0, {20'h0, 4'(m), 5'h0, b[0], 2'h0}, grp[g],
                32'h3f, v, c);
          end
        end
      end
    end
    run(16'h9c00, 32'h0, 32'h0, OC_NONE, 32'h3f, 32'h0, 32'h0);
    wrap_up();
  end
endmodule // tb_top

bind odj_decoder odj_asserts #(.ADDR_W(ADDR_W)) chk_u (
  .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .dec_done(dec_done), .power_loss_irq_en(power_loss_irq_en), .mem_writable(mem_writable)
);
